// ==== src/ihm_consts.svh ====
// Constants for the host memory port: timing, decode and pin counts.
// Assumes a single 125 MHz clock and host pins brought in raw from the board.
// Summary of operation
// - Data drivers on only during claimed reads
// - Pull channel ready low until done
// - Interrupt on one of six lines
// - Refresh cycles are never claimed
// - Strap selects card or ISA mode
// - Sleep indicator shows power down mode
// - Drive 17-bit local memory address
// - 8-bit two-way local data bus
// - Flash enable for core or host
// - SRAM enable for core or host
// - Aux enable for core accesses only
// - Output enable during local reads
// - Write enable during local writes
// - Test input enters manufacturing test mode
// - One main clock runs everything
// - Sleep timer counts 32 kHz crystal
`ifndef IHM_CONSTS_SVH
`define IHM_CONSTS_SVH
`define IHM_CLK_MHZ 125
`define IHM_LOCAL_ACC_NS 70
`define IHM_LOCAL_ACC_CYC ((`IHM_LOCAL_ACC_NS * `IHM_CLK_MHZ + 999) / 1000)
`define IHM_UPPER_W 7
`define IHM_LOWER_W 17
`define IHM_DATA_W 8
`define IHM_IRQ_LINES 6
`define IHM_IO_OFS_W 4
`define IHM_SLEEP_W 16
`define IHM_STRAP_ISA 1'b0
`endif

// ==== src/ihm_pkg.sv ====
// Types shared by the host memory port.
// Assumes the constants header is on the include path.
`include "ihm_consts.svh"
package ihm_pkg;
   // Host strobes and qualifiers as on the pins, active low where marked
   typedef struct packed {
      logic memr_n;
      logic memw_n;
      logic ior_n;
      logic iow_n;
      logic aen;
      logic bale;
      logic rfrsh_n;
   } ihm_strobe_t;
   // Owner of the local bus
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_HACC = 3'b001,
      ST_HEND = 3'b010,
      ST_CACC = 3'b011,
      ST_CEND = 3'b100
   } ihm_state_t;
   // Local bus target
   typedef enum logic [1:0] {
      TGT_FLASH = 2'b00,
      TGT_SRAM = 2'b01,
      TGT_AUX = 2'b10
   } ihm_tgt_t;
endpackage : ihm_pkg

// ==== src/ihm_host_port.sv ====
// Host bus bridge: ISA decode, channel ready, interrupts, local memory bus, sleep.
// Assumes raw host pins at the ports and an embedded core on the user side.
`timescale 1ns/1ps
`include "ihm_consts.svh"
module ihm_host_port
   import ihm_pkg::*;
#(
   parameter logic [`IHM_UPPER_W-1:0] MEM_BASE = 7'h06,
   parameter logic [11:0] IO_BASE = 12'h030,
   parameter int LOCAL_WAIT = `IHM_LOCAL_ACC_CYC
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Host address, data and strobes
   input wire logic [`IHM_UPPER_W-1:0] host_upper_addr,
   input wire logic [`IHM_LOWER_W-1:0] host_lower_addr,
   input wire logic [`IHM_DATA_W-1:0] host_data_in,
   output logic [`IHM_DATA_W-1:0] host_data_out,
   output logic host_data_oe_n,
   input wire ihm_strobe_t host_strobes,
   output logic host_chrdy_out,
   output logic host_chrdy_oe_n,
   output logic [`IHM_IRQ_LINES-1:0] host_irq_out,
   output logic [`IHM_IRQ_LINES-1:0] host_irq_oe_n,
   // Straps, test and sleep pins
   input wire logic host_bus_select_strap,
   input wire logic test_mode_in,
   input wire logic sleep_crystal_pins,
   output logic sleep_indicator,
   output logic test_mode_active,
   output logic isa_mode_active,
   // Local memory bus
   output logic [`IHM_LOWER_W-1:0] local_mem_addr,
   input wire logic [`IHM_DATA_W-1:0] local_mem_data_in,
   output logic [`IHM_DATA_W-1:0] local_mem_data_out,
   output logic local_mem_data_oe_n,
   output logic flash_select_n,
   output logic sram_select_n,
   output logic aux_periph_select_n,
   output logic local_read_enable_n,
   output logic local_write_enable_n,
   // Core side: local access request
   input wire logic core_req,
   input wire logic core_we,
   input wire ihm_tgt_t core_tgt,
   input wire logic [`IHM_LOWER_W-1:0] core_addr,
   input wire logic [`IHM_DATA_W-1:0] core_wdata,
   output logic core_ack,
   output logic [`IHM_DATA_W-1:0] core_rdata,
   // Core side: host page choice, I/O window, interrupt and sleep control
   input wire logic host_page_sram,
   input wire logic [`IHM_DATA_W-1:0] io_rdata,
   output logic io_wr_pulse,
   output logic [`IHM_IO_OFS_W-1:0] io_wr_ofs,
   output logic [`IHM_DATA_W-1:0] io_wr_data,
   input wire logic irq_req,
   input wire logic irq_enable,
   input wire logic [2:0] irq_select,
   input wire logic sleep_req,
   input wire logic [`IHM_SLEEP_W-1:0] sleep_period,
   output logic sleep_wake
);
   initial begin
      if (LOCAL_WAIT < 1 || LOCAL_WAIT > 255) $error("LOCAL_WAIT out of range");
   end

   // Two-flop synchronisers on every host pin
   ihm_strobe_t stb_s1_r, stb_s2_r;
   logic [`IHM_UPPER_W-1:0] la_s1_r, la_s2_r;
   logic [`IHM_LOWER_W-1:0] sa_s1_r, sa_s2_r;
   logic [`IHM_DATA_W-1:0] sd_s1_r, sd_s2_r;
   logic [2:0] misc_s1_r, misc_s2_r;   // strap, test, crystal
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         stb_s1_r <= '{memr_n: 1'b1, memw_n: 1'b1, ior_n: 1'b1, iow_n: 1'b1, aen: 1'b1, bale: 1'b0, rfrsh_n: 1'b1};
         stb_s2_r <= '{memr_n: 1'b1, memw_n: 1'b1, ior_n: 1'b1, iow_n: 1'b1, aen: 1'b1, bale: 1'b0, rfrsh_n: 1'b1};
         la_s1_r <= '0;
         la_s2_r <= '0;
         sa_s1_r <= '0;
         sa_s2_r <= '0;
         sd_s1_r <= '0;
         sd_s2_r <= '0;
         misc_s1_r <= '0;
         misc_s2_r <= '0;
      end else begin
         stb_s1_r <= host_strobes;
         stb_s2_r <= stb_s1_r;
         la_s1_r <= host_upper_addr;
         la_s2_r <= la_s1_r;
         sa_s1_r <= host_lower_addr;
         sa_s2_r <= sa_s1_r;
         sd_s1_r <= host_data_in;
         sd_s2_r <= sd_s1_r;
         misc_s1_r <= {host_bus_select_strap, test_mode_in, sleep_crystal_pins};
         misc_s2_r <= misc_s1_r;
      end
   end

   // Upper address captured while the latch enable is high
   logic [`IHM_UPPER_W-1:0] la_hold_r;
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         la_hold_r <= '0;
      end else if (stb_s2_r.bale) begin
         la_hold_r <= la_s2_r;
      end
   end

   // Strap caught once the synchroniser holds the pin, not its reset value
   logic strap_done_r, isa_r, test_r;
   logic [1:0] strap_wait_r;   // Edges since reset release
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         strap_done_r <= 1'b0;
         isa_r <= 1'b0;
         strap_wait_r <= 2'b00;
      end else if (!strap_done_r) begin
         if (strap_wait_r == 2'b10) begin
            strap_done_r <= 1'b1;
            isa_r <= (misc_s2_r[2] == `IHM_STRAP_ISA);
         end else begin
            strap_wait_r <= strap_wait_r + 2'b01;
         end
      end
   end

   // Test mode follows its pin
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         test_r <= 1'b0;
      end else begin
         test_r <= misc_s2_r[1];
      end
   end

   // Host cycle decode
   logic live, refresh, mem_rd, mem_wr, mem_hit, host_go, io_hit, io_rd, io_wr;
   assign live = isa_r && strap_done_r && !test_r;
   assign refresh = !stb_s2_r.rfrsh_n;
   assign mem_rd = !stb_s2_r.memr_n;
   assign mem_wr = !stb_s2_r.memw_n;
   assign mem_hit = (la_hold_r == MEM_BASE);
   assign host_go = live && !refresh && mem_hit && (mem_rd || mem_wr);
   assign io_hit = live && !stb_s2_r.aen && (sa_s2_r[15:4] == IO_BASE);
   assign io_rd = io_hit && !stb_s2_r.ior_n;
   assign io_wr = io_hit && !stb_s2_r.iow_n;

   // Local bus state machine
   ihm_state_t state_r, state_nxt;
   logic [7:0] wait_r;
   logic host_wr_r, core_own_r;
   // One local access per host cycle
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (host_go) begin
               state_nxt = ST_HACC;
            end else if (core_req) begin
               state_nxt = ST_CACC;
            end
         end
         ST_HACC: begin
            if (wait_r == 8'h00) state_nxt = ST_HEND;
         end
         ST_HEND: begin
            if (stb_s2_r.memr_n && stb_s2_r.memw_n) state_nxt = ST_IDLE;
         end
         ST_CACC: begin
            if (wait_r == 8'h00) state_nxt = ST_CEND;
         end
         ST_CEND: state_nxt = ST_IDLE;
         default: state_nxt = ST_IDLE;
      endcase
   end

   // State and wait counter
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         state_r <= ST_IDLE;
         wait_r <= 8'h00;
      end else begin
         state_r <= state_nxt;
         if (state_r == ST_IDLE) begin
            wait_r <= 8'(LOCAL_WAIT - 1);
         end else if (wait_r != 8'h00) begin
            wait_r <= wait_r - 8'h01;
         end
      end
   end

   // Local bus drive; one owner, one enable
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         local_mem_addr <= '0;
         local_mem_data_out <= '0;
         local_mem_data_oe_n <= 1'b1;
         flash_select_n <= 1'b1;
         sram_select_n <= 1'b1;
         aux_periph_select_n <= 1'b1;
         local_read_enable_n <= 1'b1;
         local_write_enable_n <= 1'b1;
         host_wr_r <= 1'b0;
         core_own_r <= 1'b0;
      end else if (state_r == ST_IDLE && state_nxt == ST_HACC) begin
         local_mem_addr <= sa_s2_r;
         local_mem_data_out <= sd_s2_r;
         local_mem_data_oe_n <= !mem_wr;
         flash_select_n <= host_page_sram;
         sram_select_n <= !host_page_sram;
         aux_periph_select_n <= 1'b1;
         local_read_enable_n <= mem_wr;
         local_write_enable_n <= !mem_wr;
         host_wr_r <= mem_wr;
         core_own_r <= 1'b0;
      end else if (state_r == ST_IDLE && state_nxt == ST_CACC) begin
         local_mem_addr <= core_addr;
         local_mem_data_out <= core_wdata;
         local_mem_data_oe_n <= !core_we;
         flash_select_n <= (core_tgt != TGT_FLASH);
         sram_select_n <= (core_tgt != TGT_SRAM);
         aux_periph_select_n <= (core_tgt != TGT_AUX);
         local_read_enable_n <= core_we;
         local_write_enable_n <= !core_we;
         core_own_r <= 1'b1;
      end else if (state_nxt == ST_HEND || state_nxt == ST_CEND) begin
         // Access over, release the bus
         local_mem_data_oe_n <= 1'b1;
         flash_select_n <= 1'b1;
         sram_select_n <= 1'b1;
         aux_periph_select_n <= 1'b1;
         local_read_enable_n <= 1'b1;
         local_write_enable_n <= 1'b1;
      end
   end

   // Read data return to core and host
   logic [`IHM_DATA_W-1:0] host_rd_r;
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         host_rd_r <= '0;
         core_rdata <= '0;
         core_ack <= 1'b0;
      end else begin
         core_ack <= (state_nxt == ST_CEND);
         if (state_r == ST_HACC && state_nxt == ST_HEND) host_rd_r <= local_mem_data_in;
         if (state_r == ST_CACC && state_nxt == ST_CEND) core_rdata <= local_mem_data_in;
      end
   end

   // Channel ready held low during the local access
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         host_chrdy_out <= 1'b0;
         host_chrdy_oe_n <= 1'b1;
      end else begin
         host_chrdy_out <= 1'b0;
         host_chrdy_oe_n <= (state_nxt != ST_HACC);
      end
   end

   // Host data drivers
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         host_data_out <= '0;
         host_data_oe_n <= 1'b1;
      end else if (state_r == ST_HEND && !host_wr_r && mem_rd) begin
         host_data_out <= host_rd_r;
         host_data_oe_n <= 1'b0;
      end else if (state_r == ST_IDLE && io_rd && !refresh) begin
         host_data_out <= io_rdata;
         host_data_oe_n <= 1'b0;
      end else begin
         host_data_oe_n <= 1'b1;
      end
   end

   // I/O write pulse on strobe assertion
   logic io_wr_d_r;
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         io_wr_d_r <= 1'b0;
         io_wr_pulse <= 1'b0;
         io_wr_ofs <= '0;
         io_wr_data <= '0;
      end else begin
         io_wr_d_r <= io_wr;
         io_wr_pulse <= io_wr && !io_wr_d_r && !refresh;
         if (io_wr && !io_wr_d_r) begin
            io_wr_ofs <= sa_s2_r[`IHM_IO_OFS_W-1:0];
            io_wr_data <= sd_s2_r;
         end
      end
   end

   // Interrupt line drive
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         host_irq_out <= '0;
         host_irq_oe_n <= '1;
      end else begin
         for (int i = 0; i < `IHM_IRQ_LINES; i++) begin
            host_irq_oe_n[i] <= !(live && irq_enable && irq_select == 3'(i));
            host_irq_out[i] <= irq_req;
         end
      end
   end

   // Sleep state and crystal-timed wake
   logic xtal_d_r, sleep_r;
   logic [`IHM_SLEEP_W-1:0] sleep_cnt_r;
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         xtal_d_r <= 1'b0;
         sleep_r <= 1'b0;
         sleep_cnt_r <= '0;
         sleep_wake <= 1'b0;
      end else begin
         xtal_d_r <= misc_s2_r[0];
         sleep_wake <= 1'b0;
         if (!sleep_r) begin
            sleep_cnt_r <= '0;
            sleep_r <= sleep_req;
         end else if (misc_s2_r[0] && !xtal_d_r) begin
            sleep_cnt_r <= sleep_cnt_r + 1'b1;
            if (sleep_cnt_r + 1'b1 >= sleep_period) begin
               sleep_r <= 1'b0;
               sleep_wake <= 1'b1;
            end
         end else if (!sleep_req) begin
            sleep_r <= 1'b0;
         end
      end
   end

   // Mode indicators
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         sleep_indicator <= 1'b0;
         test_mode_active <= 1'b0;
         isa_mode_active <= 1'b0;
      end else begin
         sleep_indicator <= sleep_r;
         test_mode_active <= test_r;
         isa_mode_active <= isa_r && strap_done_r;
      end
   end

   // Checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   sequence s_host_start;
      state_r == ST_IDLE ##1 state_r == ST_HACC;
   endsequence
   sequence s_host_done;
      ##[1:260] state_r == ST_HEND;
   endsequence
   a_host_one_access: assert property (s_host_start |-> s_host_done)
      else $error("host access did not finish");
   a_chrdy_held: assert property (state_r == ST_HACC |-> !host_chrdy_oe_n)
      else $error("channel ready released early");
   a_sd_only_read: assert property (!host_data_oe_n |-> $past(mem_rd || io_rd))
      else $error("host data driven without read");
   a_one_select: assert property ($countones({flash_select_n, sram_select_n, aux_periph_select_n}) >= 2)
      else $error("two chip enables");
   a_aux_core_only: assert property (!aux_periph_select_n |-> core_own_r)
      else $error("aux enabled by host");
   a_refresh_skip: assert property (state_r == ST_IDLE && refresh |=> state_r != ST_HACC)
      else $error("refresh claimed");
   a_rd_wr_excl: assert property (!(local_read_enable_n == 1'b0 && local_write_enable_n == 1'b0))
      else $error("read and write enable together");
   a_wr_data_drive: assert property (!local_write_enable_n |-> !local_mem_data_oe_n)
      else $error("write without data drive");
   a_irq_single: assert property ($countones(~host_irq_oe_n) <= 1)
      else $error("more than one irq line");
   a_test_quiet: assert property (test_r |=> state_r != ST_HACC)
      else $error("host access in test mode");
   a_sleep_show: assert property ($rose(sleep_r) |=> sleep_indicator ##1 1'b1)
      else $error("sleep not shown");
endmodule : ihm_host_port

// ==== sim/ihm_isa_host.sv ====
// Host system model: runs ISA memory and I/O cycles against the port.
// Assumes the port's ready and data pins are split, oe_n low while driving.
`timescale 1ns/1ps
module ihm_isa_host
   import ihm_pkg::*;
(
   // Clock
   input wire logic mclk,
   // Host pins driven here
   output logic [6:0] host_upper_addr,
   output logic [16:0] host_lower_addr,
   output logic [7:0] host_data_in,
   output ihm_strobe_t host_strobes,
   // Device answers
   input wire logic host_chrdy_oe_n,
   input wire logic [7:0] host_data_out,
   input wire logic host_data_oe_n
);
   // Idle bus from time zero
   initial begin
      host_upper_addr = 7'h00;
      host_lower_addr = 17'h0_0000;
      host_data_in = 8'h00;
      host_strobes = 7'h79;
   end

   // One bus cycle: kind 0 mem read, 1 mem write, 2 io read, 3 io write
   task automatic run(input int kind, input logic [6:0] up, input logic [16:0] lo, input logic [7:0] wd,
                      input logic rf_n, input logic aen_v, output logic [7:0] rd, output logic claimed);
      int n;
      claimed = 1'b0;
      rd = 8'h00;
      @(negedge mclk);
      host_upper_addr = up;
      host_lower_addr = lo;
      host_strobes.aen = aen_v;
      host_strobes.rfrsh_n = rf_n;
      host_strobes.bale = 1'b1;
      repeat (3) @(negedge mclk);
      host_strobes.bale = 1'b0;
      host_data_in = wd;
      case (kind)
         0: host_strobes.memr_n = 1'b0;
         1: host_strobes.memw_n = 1'b0;
         2: host_strobes.ior_n = 1'b0;
         default: host_strobes.iow_n = 1'b0;
      endcase
      // Hold strobe while ready is pulled low
      for (n = 0; n < 8 && host_chrdy_oe_n !== 1'b0; n++) @(negedge mclk);
      for (n = 0; n < 60 && host_chrdy_oe_n === 1'b0; n++) begin
         claimed = 1'b1;
         @(negedge mclk);
      end
      // Read data shows after ready is released
      if (kind == 0 || kind == 2) begin
         for (n = 0; n < 8 && host_data_oe_n !== 1'b0; n++) @(negedge mclk);
         rd = host_data_out;
         if (host_data_oe_n === 1'b0) claimed = 1'b1;
      end
      @(posedge mclk);
      @(negedge mclk);
      host_strobes[6:3] = 4'hF;
      // Released data lines show the inverse, not the old value
      host_data_in = ~wd;
      repeat (6) @(negedge mclk);
   endtask : run
endmodule : ihm_isa_host

// ==== sim/ihm_host_port_test.sv ====
// Bench for the host port: host cycles, core accesses, io, irq, sleep, modes.
// Assumes the host model file and the design package are compiled first.
`timescale 1ns/1ps
module ihm_host_port_test;
   import ihm_pkg::*;
   // Clock, reset, straps
   logic mclk, rst_n, host_bus_select_strap, test_mode_in, sleep_crystal_pins;
   // Host pins
   logic [6:0] host_upper_addr;
   logic [16:0] host_lower_addr, local_mem_addr, core_addr;
   logic [7:0] host_data_in, host_data_out, local_mem_data_in, local_mem_data_out, core_wdata, core_rdata;
   logic [7:0] io_rdata, io_wr_data;
   ihm_strobe_t host_strobes;
   logic host_data_oe_n, host_chrdy_out, host_chrdy_oe_n, sleep_indicator, test_mode_active, isa_mode_active;
   logic [5:0] host_irq_out, host_irq_oe_n;
   // Local bus and core side
   logic local_mem_data_oe_n, flash_select_n, sram_select_n, aux_periph_select_n;
   logic local_read_enable_n, local_write_enable_n, core_req, core_we, core_ack, host_page_sram;
   ihm_tgt_t core_tgt;
   logic io_wr_pulse, irq_req, irq_enable, sleep_req, sleep_wake;
   logic [3:0] io_wr_ofs;
   logic [2:0] irq_select, sel, l_sel;
   logic [15:0] sleep_period;
   // Bench bookkeeping
   int n_fail = 0, tests_run = 0, n_acc = 0, n_iow = 0;
   logic [16:0] l_addr;
   logic [7:0] l_wd, l_iod;
   logic [3:0] l_ofs;
   logic l_rd, l_wr, l_doe, doe_seen;
   logic [2:0] sel_prev = 3'h7;

   ihm_host_port DUT (.mclk, .rst_n, .host_upper_addr, .host_lower_addr, .host_data_in, .host_data_out,
      .host_data_oe_n, .host_strobes, .host_chrdy_out, .host_chrdy_oe_n, .host_irq_out, .host_irq_oe_n,
      .host_bus_select_strap, .test_mode_in, .sleep_crystal_pins, .sleep_indicator, .test_mode_active,
      .isa_mode_active, .local_mem_addr, .local_mem_data_in, .local_mem_data_out, .local_mem_data_oe_n,
      .flash_select_n, .sram_select_n, .aux_periph_select_n, .local_read_enable_n, .local_write_enable_n,
      .core_req, .core_we, .core_tgt, .core_addr, .core_wdata, .core_ack, .core_rdata, .host_page_sram,
      .io_rdata, .io_wr_pulse, .io_wr_ofs, .io_wr_data, .irq_req, .irq_enable, .irq_select, .sleep_req,
      .sleep_period, .sleep_wake);
   ihm_isa_host host (.mclk, .host_upper_addr, .host_lower_addr, .host_data_in, .host_strobes,
      .host_chrdy_oe_n, .host_data_out, .host_data_oe_n);

   // Local memory: data from address while read, inverted otherwise
   assign local_mem_data_in = (local_mem_addr[7:0] ^ 8'h3C) ^ {8{local_read_enable_n}};
   assign sel = {flash_select_n, sram_select_n, aux_periph_select_n};
   // Clock and crystal
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   initial begin
      sleep_crystal_pins = 1'b0;
      forever #40 sleep_crystal_pins = ~sleep_crystal_pins;
   end

   // Compare and count
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // Local bus monitor, sampled mid-cycle
   always @(negedge mclk) begin
      if (rst_n) begin
         if (sel != 3'h7) check($countones(~sel), 1);
         if (sel_prev == 3'h7 && sel != 3'h7) begin
            n_acc++;
            {l_sel, l_addr, l_rd, l_wr} = {sel, local_mem_addr, !local_read_enable_n, !local_write_enable_n};
         end
         if (!local_write_enable_n) {l_doe, l_wd} = {local_mem_data_oe_n, local_mem_data_out};
         if (!host_data_oe_n) doe_seen = 1'b1;
         if (io_wr_pulse) begin
            n_iow++;
            {l_ofs, l_iod} = {io_wr_ofs, io_wr_data};
         end
      end
      sel_prev = sel;
   end

   task automatic core_acc(input logic we, input ihm_tgt_t tgt, input logic [16:0] a, input logic [7:0] wd,
                           output logic [7:0] rd);
      int n;
      @(negedge mclk);
      core_tgt = tgt;
      {core_req, core_we, core_addr, core_wdata} = {1'b1, we, a, wd};
      for (n = 0; n < 40 && core_ack !== 1'b1; n++) @(negedge mclk);
      rd = core_rdata;
      check(core_ack, 1'b1);
      core_req = 1'b0;
   endtask : core_acc

   // Host memory read from flash, write to SRAM
   task automatic t_host_mem();
      logic [7:0] rd;
      logic cl;
      int a0;
      {host_page_sram, a0} = {1'b0, n_acc};
      host.run(0, 7'h06, 17'h1_2345, 8'h00, 1'b1, 1'b0, rd, cl);
      check(cl, 1'b1);
      check(rd, 8'h79);
      check(n_acc - a0, 1);
      check({l_sel, l_rd, l_wr}, 5'h0E);
      check(l_addr, 17'h1_2345);
      {host_page_sram, a0, doe_seen} = {1'b1, n_acc, 1'b0};
      host.run(1, 7'h06, 17'h0_0777, 8'hC3, 1'b1, 1'b0, rd, cl);
      check(n_acc - a0, 1);
      check({l_sel, l_rd, l_wr}, 5'h15);
      check({l_doe, l_wd}, 9'h0C3);
      check(doe_seen, 1'b0);
      a0 = n_acc;
      host.run(0, 7'h06, 17'h1_2345, 8'h00, 1'b0, 1'b0, rd, cl);
      check(cl, 1'b0);
      check(n_acc - a0, 0);
      host.run(0, 7'h07, 17'h1_2345, 8'h00, 1'b1, 1'b0, rd, cl);
      check(cl, 1'b0);
      check(n_acc - a0, 0);
   endtask : t_host_mem

   // Core reaches aux and flash
   task automatic t_core();
      logic [7:0] rd;
      core_acc(1'b0, TGT_AUX, 17'h0_00F0, 8'h00, rd);
      check({rd, l_sel, l_rd}, 12'hCC_D);
      core_acc(1'b1, TGT_FLASH, 17'h1_0001, 8'h5A, rd);
      check({l_sel, l_wr, l_wd}, 12'h75_A);
   endtask : t_core

   // Decoded and undecoded io cycles
   task automatic t_io();
      logic [7:0] rd;
      logic cl;
      int w0;
      {io_rdata, w0} = {8'h6B, n_iow};
      host.run(3, 7'h00, 17'h0_0305, 8'h9E, 1'b1, 1'b0, rd, cl);
      check({5'(n_iow - w0), l_ofs, l_iod}, 17'h0_159E);
      host.run(3, 7'h00, 17'h0_0305, 8'h11, 1'b1, 1'b1, rd, cl);
      check(n_iow - w0, 1);
      host.run(2, 7'h00, 17'h0_0302, 8'h00, 1'b1, 1'b0, rd, cl);
      check({cl, rd}, 9'h16B);
      host.run(2, 7'h00, 17'h0_0042, 8'h00, 1'b1, 1'b0, rd, cl);
      check(cl, 1'b0);
   endtask : t_io

   // Each of the six interrupt lines in turn
   task automatic t_irq();
      {irq_req, irq_enable} = 2'h3;
      for (int s = 0; s < 6; s++) begin
         irq_select = 3'(s);
         repeat (4) @(negedge mclk);
         check({host_irq_oe_n, host_irq_out[s]}, {~(6'h01 << s), 1'b1});
      end
      irq_enable = 1'b0;
      repeat (4) @(negedge mclk);
      check(host_irq_oe_n, 6'h3F);
   endtask : t_irq

   // Test mode blocks host claims
   task automatic t_test_mode();
      logic [7:0] rd;
      logic cl;
      test_mode_in = 1'b1;
      repeat (4) @(negedge mclk);
      check(test_mode_active, 1'b1);
      host.run(0, 7'h06, 17'h0_0100, 8'h00, 1'b1, 1'b0, rd, cl);
      check(cl, 1'b0);
      test_mode_in = 1'b0;
   endtask : t_test_mode

   // Sleep for three crystal edges
   task automatic t_sleep();
      int n;
      {sleep_period, sleep_req} = {16'h0003, 1'b1};
      repeat (4) @(negedge mclk);
      check(sleep_indicator, 1'b1);
      for (n = 4; n < 200 && sleep_wake !== 1'b1; n++) @(negedge mclk);
      check({sleep_wake, n >= 20, n <= 44}, 3'h7);
      sleep_req = 1'b0;
      repeat (4) @(negedge mclk);
      check(sleep_indicator, 1'b0);
   endtask : t_sleep

   // Card strap: nothing claimed
   task automatic t_strap();
      logic [7:0] rd;
      logic cl;
      {host_bus_select_strap, rst_n} = 2'h2;
      repeat (8) @(negedge mclk);
      rst_n = 1'b1;
      repeat (6) @(negedge mclk);
      check(isa_mode_active, 1'b0);
      host.run(0, 7'h06, 17'h0_0200, 8'h00, 1'b1, 1'b0, rd, cl);
      check(cl, 1'b0);
   endtask : t_strap

   task automatic test_done();
      $display("Checks run %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : test_done

   // Watchdog
   initial begin
      repeat (20000) @(posedge mclk);
      n_fail++;
      test_done();
   end

   // Main sequence
   initial begin
      {rst_n, host_bus_select_strap, test_mode_in, host_page_sram, core_req, core_we} = 6'h00;
      core_tgt = TGT_FLASH;
      {core_addr, core_wdata, io_rdata} = '0;
      {irq_req, irq_enable, irq_select, sleep_req, sleep_period} = '0;
      repeat (8) @(negedge mclk);
      rst_n = 1'b1;
      repeat (6) @(negedge mclk);
      check({sel, local_read_enable_n, local_write_enable_n, host_data_oe_n, host_chrdy_oe_n, host_chrdy_out}, 8'hFE);
      check(isa_mode_active, 1'b1);
      t_host_mem();
      t_core();
      t_io();
      t_irq();
      t_test_mode();
      t_sleep();
      t_strap();
      test_done();
   end
endmodule : ihm_host_port_test
